// [rtl/mcp_main_clock_pll_sequencer.sv]
// main oscillator, pll, master clock and slow clock sequencer
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - out of reset the block runs from the fast rc at 4 MHz with neither crystal nor pll chosen.
// - the main oscillator offers a 4/8/12 MHz rc and a bypassable 3 to 20 MHz crystal.
// - one keyed write with startup count, rc enable and crystal enable starts the crystal.
// - the crystal-stable flag rises once the programmed startup count has elapsed.
// - the startup count is in units of eight slow clock periods.
// - setting the source select moves main onto the crystal and raises a done flag.
// - the pll is a divider then a multiplier, both held with a startup count in one register.
// - after a pll write the lock flag rises when the pll startup count expires.
// - each master clock write clears the ready flag and sets it again later.
// - the slow clock starts on rc, valid after about 100 us, crystal powered but unused.
// - a keyed supply write with crystal select moves slow clock to crystal, shown in status.
module mcp_main_clock_pll_sequencer (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic             rc_osc_enable_o,
	output logic      [1:0]  rc_freq_o,
	output logic             xtal_osc_enable_o,
	output logic             xtal_bypass_o,
	output logic             main_on_xtal_o,
	output logic      [7:0]  pll_div_o,
	output logic      [10:0] pll_factor_up_o,
	output logic      [1:0]  mck_source_o,
	output logic      [2:0]  mck_prescale_o,
	output logic             slow_on_xtal_o,
	output logic             slow_clock_valid_o
);
	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic rst_s1_reg;
	logic rst_n;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_s1_reg <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n      <= rst_s1_reg;
		end
	end

	logic slow_tick;

	mcp_slow_tick #(
		.DIV(mcp_pkg::SLOW_DIV)
	) u_tick (
		.clk_i  (clk_i),
		.rst_n_i(rst_n),
		.tick_o (slow_tick)
	);

	// ---------------------------------------------------------------
	// write decode
	// ---------------------------------------------------------------
	logic wr_mor;
	logic wr_pll;
	logic wr_mck;
	logic wr_sup;

	assign wr_mor = wr_i && addr_i == mcp_pkg::ADDR_MAIN_OSC
		&& wdata_i[mcp_pkg::MOR_KEY_LO +: 8] == mcp_pkg::MOR_KEY;
	assign wr_pll = wr_i && addr_i == mcp_pkg::ADDR_PLL_CONFIG;
	assign wr_mck = wr_i && addr_i == mcp_pkg::ADDR_MASTER_CLK;
	assign wr_sup = wr_i && addr_i == mcp_pkg::ADDR_SUPPLY_CTL
		&& wdata_i[mcp_pkg::SUP_KEY_LO +: 8] == mcp_pkg::SUP_KEY;

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic        rc_en_reg, rc_en_next;
	logic [1:0]  rc_freq_reg, rc_freq_next;
	logic        xt_en_reg, xt_en_next;
	logic        bypass_reg, bypass_next;
	logic        src_sel_reg, src_sel_next;
	logic [7:0]  xt_st_reg, xt_st_next;
	logic [10:0] xt_cnt_reg, xt_cnt_next;
	logic        xt_stable_reg, xt_stable_next;
	logic [2:0]  sw_cnt_reg, sw_cnt_next;
	logic        src_done_reg, src_done_next;
	logic        main_xt_reg, main_xt_next;
	logic [7:0]  div_reg, div_next;
	logic [10:0] mul_reg, mul_next;
	logic [5:0]  pcnt_cfg_reg, pcnt_cfg_next;
	logic [5:0]  pcnt_reg, pcnt_next;
	logic        lock_reg, lock_next;
	logic [1:0]  css_reg, css_next;
	logic [2:0]  pres_reg, pres_next;
	logic [2:0]  mck_cnt_reg, mck_cnt_next;
	logic        mck_rdy_reg, mck_rdy_next;
	logic [11:0] srv_cnt_reg, srv_cnt_next;
	logic        slow_valid_reg, slow_valid_next;
	logic        slow_xt_reg, slow_xt_next;
	logic [2:0]  ssw_cnt_reg, ssw_cnt_next;
	logic [31:0] rdata_reg, rdata_next;

	always_comb begin
		rc_en_next      = rc_en_reg;
		rc_freq_next    = rc_freq_reg;
		xt_en_next      = xt_en_reg;
		bypass_next     = bypass_reg;
		src_sel_next    = src_sel_reg;
		xt_st_next      = xt_st_reg;
		xt_cnt_next     = xt_cnt_reg;
		xt_stable_next  = xt_stable_reg;
		sw_cnt_next     = sw_cnt_reg;
		src_done_next   = src_done_reg;
		main_xt_next    = main_xt_reg;
		div_next        = div_reg;
		mul_next        = mul_reg;
		pcnt_cfg_next   = pcnt_cfg_reg;
		pcnt_next       = pcnt_reg;
		lock_next       = lock_reg;
		css_next        = css_reg;
		pres_next       = pres_reg;
		mck_cnt_next    = mck_cnt_reg;
		mck_rdy_next    = mck_rdy_reg;
		srv_cnt_next    = srv_cnt_reg;
		slow_valid_next = slow_valid_reg;
		slow_xt_next    = slow_xt_reg;
		ssw_cnt_next    = ssw_cnt_reg;

		// crystal startup, counted in slow ticks
		if (wr_mor) begin
			rc_en_next   = wdata_i[mcp_pkg::MOR_RC_EN];
			rc_freq_next = wdata_i[mcp_pkg::MOR_RC_FREQ_LO +: 2];
			bypass_next  = wdata_i[mcp_pkg::MOR_BYPASS];
			xt_st_next   = wdata_i[mcp_pkg::MOR_XTAL_ST_LO +: mcp_pkg::MOR_XTAL_ST_W];
			src_sel_next = wdata_i[mcp_pkg::MOR_SRC_SEL];
			xt_en_next   = wdata_i[mcp_pkg::MOR_XTAL_EN];
			if (wdata_i[mcp_pkg::MOR_XTAL_EN] && !xt_en_reg) begin
				// unit of eight slow periods
				xt_cnt_next    = {wdata_i[mcp_pkg::MOR_XTAL_ST_LO +: 8], 3'h0};
				xt_stable_next = 1'b0;
			end else if (!wdata_i[mcp_pkg::MOR_XTAL_EN]) begin
				xt_stable_next = 1'b0;
			end
			if (wdata_i[mcp_pkg::MOR_SRC_SEL] != src_sel_reg) begin
				sw_cnt_next   = 3'(mcp_pkg::SRC_SWITCH_CYC);
				src_done_next = 1'b0;
			end
		end else if (xt_en_reg && !xt_stable_reg) begin
			if (bypass_reg || xt_cnt_reg == 11'h000) begin
				xt_stable_next = 1'b1;
			end else if (slow_tick) begin
				xt_cnt_next = xt_cnt_reg - 11'h001;
			end
		end
		if (!wr_mor && sw_cnt_reg != 3'h0) begin
			// wait for the crystal before moving onto it
			if (!src_sel_reg || xt_stable_reg) begin
				sw_cnt_next = sw_cnt_reg - 3'h1;
				if (sw_cnt_reg == 3'h1) begin
					main_xt_next  = src_sel_reg;
					src_done_next = src_sel_reg;
				end
			end
		end

		// pll lock countdown in slow ticks
		if (wr_pll) begin
			div_next      = wdata_i[mcp_pkg::PLL_DIV_LO +: mcp_pkg::PLL_DIV_W];
			mul_next      = wdata_i[mcp_pkg::PLL_MUL_LO +: mcp_pkg::PLL_MUL_W];
			pcnt_cfg_next = wdata_i[mcp_pkg::PLL_CNT_LO +: mcp_pkg::PLL_CNT_W];
			pcnt_next     = wdata_i[mcp_pkg::PLL_CNT_LO +: mcp_pkg::PLL_CNT_W];
			lock_next     = 1'b0;
		end else if (!lock_reg && div_reg != 8'h00 && mul_reg != 11'h000) begin
			if (pcnt_reg == 6'h00) begin
				lock_next = 1'b1;
			end else if (slow_tick) begin
				pcnt_next = pcnt_reg - 6'h01;
			end
		end

		// master clock change, ready drops on every write
		if (wr_mck) begin
			css_next     = wdata_i[mcp_pkg::MCK_CSS_LO +: 2];
			pres_next    = wdata_i[mcp_pkg::MCK_PRES_LO +: 3];
			mck_cnt_next = 3'(mcp_pkg::MCK_SWITCH_CYC);
			mck_rdy_next = 1'b0;
		end else if (mck_cnt_reg != 3'h0) begin
			mck_cnt_next = mck_cnt_reg - 3'h1;
			mck_rdy_next = mck_cnt_reg == 3'h1;
		end

		// slow clock: rc first, crystal on request
		if (srv_cnt_reg != 12'h000) begin
			srv_cnt_next = srv_cnt_reg - 12'h001;
		end else begin
			slow_valid_next = 1'b1;
		end
		if (wr_sup && wdata_i[mcp_pkg::SUP_XTAL_SEL] && !slow_xt_reg && ssw_cnt_reg == 3'h0) begin
			ssw_cnt_next = 3'(mcp_pkg::SLOW_SW_CYC);
		end else if (ssw_cnt_reg != 3'h0) begin
			ssw_cnt_next = ssw_cnt_reg - 3'h1;
			if (ssw_cnt_reg == 3'h1) begin
				slow_xt_next = 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// read mux
	// ---------------------------------------------------------------
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				mcp_pkg::ADDR_MAIN_OSC: begin
					rdata_next[mcp_pkg::MOR_XTAL_EN]                         = xt_en_reg;
					rdata_next[mcp_pkg::MOR_BYPASS]                          = bypass_reg;
					rdata_next[mcp_pkg::MOR_RC_EN]                           = rc_en_reg;
					rdata_next[mcp_pkg::MOR_RC_FREQ_LO +: 2]                 = rc_freq_reg;
					rdata_next[mcp_pkg::MOR_XTAL_ST_LO +: 8]                 = xt_st_reg;
					rdata_next[mcp_pkg::MOR_SRC_SEL]                         = src_sel_reg;
				end
				mcp_pkg::ADDR_PLL_CONFIG: begin
					rdata_next[mcp_pkg::PLL_DIV_LO +: mcp_pkg::PLL_DIV_W] = div_reg;
					rdata_next[mcp_pkg::PLL_CNT_LO +: mcp_pkg::PLL_CNT_W] = pcnt_cfg_reg;
					rdata_next[mcp_pkg::PLL_MUL_LO +: mcp_pkg::PLL_MUL_W] = mul_reg;
				end
				mcp_pkg::ADDR_MASTER_CLK: begin
					rdata_next[mcp_pkg::MCK_CSS_LO +: 2]  = css_reg;
					rdata_next[mcp_pkg::MCK_PRES_LO +: 3] = pres_reg;
				end
				mcp_pkg::ADDR_STATUS: begin
					rdata_next[mcp_pkg::SR_XTAL_STABLE] = xt_stable_reg;
					rdata_next[mcp_pkg::SR_LOCK]        = lock_reg;
					rdata_next[mcp_pkg::SR_MCK_READY]   = mck_rdy_reg;
					rdata_next[mcp_pkg::SR_SRC_DONE]    = src_done_reg;
				end
				mcp_pkg::ADDR_SUPPLY_ST: begin
					rdata_next[mcp_pkg::SUP_SRC_FLAG] = slow_xt_reg;
				end
				default: rdata_next = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			// fast rc at 4 MHz, nothing else chosen
			rc_en_reg      <= 1'b1;
			rc_freq_reg    <= mcp_pkg::RC_FREQ_4MHZ;
			xt_en_reg      <= 1'b0;
			bypass_reg     <= 1'b0;
			src_sel_reg    <= 1'b0;
			xt_st_reg      <= 8'h00;
			xt_cnt_reg     <= 11'h000;
			xt_stable_reg  <= 1'b0;
			sw_cnt_reg     <= 3'h0;
			src_done_reg   <= 1'b0;
			main_xt_reg    <= 1'b0;
			div_reg        <= 8'h00;
			mul_reg        <= 11'h000;
			pcnt_cfg_reg   <= 6'h00;
			pcnt_reg       <= 6'h00;
			lock_reg       <= 1'b0;
			css_reg        <= mcp_pkg::CSS_MAIN;
			pres_reg       <= 3'h0;
			mck_cnt_reg    <= 3'h0;
			mck_rdy_reg    <= 1'b1;
			srv_cnt_reg    <= 12'(mcp_pkg::SLOW_RC_CYC);
			slow_valid_reg <= 1'b0;
			slow_xt_reg    <= 1'b0;
			ssw_cnt_reg    <= 3'h0;
			rdata_reg      <= 32'h0000_0000;
		end else begin
			rc_en_reg      <= rc_en_next;
			rc_freq_reg    <= rc_freq_next;
			xt_en_reg      <= xt_en_next;
			bypass_reg     <= bypass_next;
			src_sel_reg    <= src_sel_next;
			xt_st_reg      <= xt_st_next;
			xt_cnt_reg     <= xt_cnt_next;
			xt_stable_reg  <= xt_stable_next;
			sw_cnt_reg     <= sw_cnt_next;
			src_done_reg   <= src_done_next;
			main_xt_reg    <= main_xt_next;
			div_reg        <= div_next;
			mul_reg        <= mul_next;
			pcnt_cfg_reg   <= pcnt_cfg_next;
			pcnt_reg       <= pcnt_next;
			lock_reg       <= lock_next;
			css_reg        <= css_next;
			pres_reg       <= pres_next;
			mck_cnt_reg    <= mck_cnt_next;
			mck_rdy_reg    <= mck_rdy_next;
			srv_cnt_reg    <= srv_cnt_next;
			slow_valid_reg <= slow_valid_next;
			slow_xt_reg    <= slow_xt_next;
			ssw_cnt_reg    <= ssw_cnt_next;
			rdata_reg      <= rdata_next;
		end
	end

	assign rdata_o            = rdata_reg;
	assign rc_osc_enable_o    = rc_en_reg;
	assign rc_freq_o          = rc_freq_reg;
	assign xtal_osc_enable_o  = xt_en_reg;
	assign xtal_bypass_o      = bypass_reg;
	assign main_on_xtal_o     = main_xt_reg;
	assign pll_div_o          = div_reg;
	assign pll_factor_up_o    = mul_reg;
	assign mck_source_o       = css_reg;
	assign mck_prescale_o     = pres_reg;
	assign slow_on_xtal_o     = slow_xt_reg;
	assign slow_clock_valid_o = slow_valid_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_mck_drop;
		@(posedge clk_i) disable iff (!rst_n) wr_mck |=> !mck_rdy_reg;
	endproperty
	a_mck_drop: assert property (p_mck_drop) else $error("ready not cleared");

	property p_mck_back;
		@(posedge clk_i) disable iff (!rst_n) wr_mck ##1 !wr_mck [*4] |=> mck_rdy_reg;
	endproperty
	a_mck_back: assert property (p_mck_back) else $error("ready not restored");

	property p_lock_clear;
		@(posedge clk_i) disable iff (!rst_n) wr_pll |=> !lock_reg;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("lock kept on write");

	property p_lock_cause;
		@(posedge clk_i) disable iff (!rst_n) $rose(lock_reg) |-> $past(pcnt_reg) == 6'h00;
	endproperty
	a_lock_cause: assert property (p_lock_cause) else $error("lock before count");

	property p_stable_cause;
		@(posedge clk_i) disable iff (!rst_n)
			$rose(xt_stable_reg) |-> xt_en_reg && ($past(xt_cnt_reg) == 11'h000 || bypass_reg);
	endproperty
	a_stable_cause: assert property (p_stable_cause) else $error("early stable");

	property p_done_needs_xtal;
		@(posedge clk_i) disable iff (!rst_n) $rose(src_done_reg) |-> xt_stable_reg;
	endproperty
	a_done_needs_xtal: assert property (p_done_needs_xtal) else $error("switch w/o xtal");

	property p_slow_switch;
		@(posedge clk_i) disable iff (!rst_n) $rose(slow_xt_reg) |-> $past(ssw_cnt_reg) == 3'h1;
	endproperty
	a_slow_switch: assert property (p_slow_switch) else $error("slow switch bad");

	property p_slow_valid;
		@(posedge clk_i) disable iff (!rst_n) $rose(slow_valid_reg) |-> $past(srv_cnt_reg) == 12'h000;
	endproperty
	a_slow_valid: assert property (p_slow_valid) else $error("slow valid early");

	property p_startup_load;
		@(posedge clk_i) disable iff (!rst_n)
			wr_mor && wdata_i[mcp_pkg::MOR_XTAL_EN] && !xt_en_reg
			|=> xt_cnt_reg == {$past(wdata_i[mcp_pkg::MOR_XTAL_ST_LO +: 8]), 3'h0};
	endproperty
	a_startup_load: assert property (p_startup_load) else $error("bad startup count");

	c_lock: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(lock_reg));
	c_stable: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(xt_stable_reg));
	c_done: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(src_done_reg));
	c_slow: cover property (@(posedge clk_i) disable iff (!rst_n) $rose(slow_xt_reg));
endmodule

// [inc/mcp_pkg.sv]
// constants for the main clock and pll sequencer
package mcp_pkg;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_MAIN_OSC   = 8'h00;
	localparam logic [7:0] ADDR_PLL_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_MASTER_CLK = 8'h08;
	localparam logic [7:0] ADDR_STATUS     = 8'h0c;
	localparam logic [7:0] ADDR_SUPPLY_CTL = 8'h10;
	localparam logic [7:0] ADDR_SUPPLY_ST  = 8'h14;

	// ---------------------------------------------------------------
	// main oscillator register fields
	// ---------------------------------------------------------------
	localparam int MOR_XTAL_EN    = 0;
	localparam int MOR_RC_EN      = 3;
	localparam int MOR_RC_FREQ_LO = 4;
	localparam int MOR_XTAL_ST_LO = 8;
	localparam int MOR_XTAL_ST_W  = 8;
	localparam int MOR_KEY_LO     = 16;
	localparam int MOR_SRC_SEL    = 24;
	localparam int MOR_BYPASS     = 1;
	localparam logic [7:0] MOR_KEY = 8'h37;
	localparam logic [1:0] RC_FREQ_4MHZ = 2'h0;

	// ---------------------------------------------------------------
	// pll register fields
	// ---------------------------------------------------------------
	localparam int PLL_DIV_LO   = 0;
	localparam int PLL_DIV_W    = 8;
	localparam int PLL_CNT_LO   = 8;
	localparam int PLL_CNT_W    = 6;
	localparam int PLL_MUL_LO   = 16;
	localparam int PLL_MUL_W    = 11;

	// ---------------------------------------------------------------
	// master clock register fields
	// ---------------------------------------------------------------
	localparam int MCK_CSS_LO  = 0;
	localparam int MCK_PRES_LO = 4;
	localparam logic [1:0] CSS_SLOW = 2'h0;
	localparam logic [1:0] CSS_MAIN = 2'h1;
	localparam logic [1:0] CSS_PLL  = 2'h2;

	// ---------------------------------------------------------------
	// status bits and supply control fields
	// ---------------------------------------------------------------
	localparam int SR_XTAL_STABLE = 0;
	localparam int SR_LOCK        = 1;
	localparam int SR_MCK_READY   = 3;
	localparam int SR_SRC_DONE    = 16;
	localparam int SUP_XTAL_SEL   = 3;
	localparam int SUP_KEY_LO     = 24;
	localparam logic [7:0] SUP_KEY = 8'ha5;
	localparam int SUP_SRC_FLAG   = 7;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ         = 40000000;
	localparam int SLOW_HZ        = 32768;
	localparam int XTAL_UNIT      = 8;
	localparam int SLOW_DIV       = CLK_HZ / SLOW_HZ;
	localparam int SLOW_RC_US     = 100;
	localparam int SLOW_RC_CYC    = SLOW_RC_US * (CLK_HZ / 1000000);
	localparam int MCK_SWITCH_CYC = 4;
	localparam int SRC_SWITCH_CYC = 4;
	localparam int SLOW_SW_CYC    = 4;
endpackage

// [rtl/mcp_slow_tick.sv]
// divider giving one-cycle slow clock enables
`timescale 1ns/1ps
module mcp_slow_tick #(
	parameter int DIV = 1220
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	output logic      tick_o
);
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic        tick_reg;
	logic        tick_next;

	always_comb begin
		tick_next = 1'b0;
		cnt_next  = cnt_reg + 16'h0001;
		if (cnt_reg == 16'(DIV - 1)) begin
			cnt_next  = 16'h0000;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg  <= 16'h0000;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_o = tick_reg;
endmodule

// [test/mcp_osc_model.sv]
// behavioural model of the oscillators and pll beside the sequencer
`timescale 1ns/1ps
module mcp_osc_model #(
	parameter int XTAL_KHZ = 12000
) (
	input  wire logic        rc_en_i,
	input  wire logic [1:0]  rc_freq_i,
	input  wire logic        xtal_en_i,
	input  wire logic        on_xtal_i,
	input  wire logic [7:0]  div_i,
	input  wire logic [10:0] factor_i,
	input  wire logic [1:0]  src_i,
	input  wire logic [2:0]  pres_i,
	output int               main_khz_o,
	output int               mck_khz_o
);
	int rc_khz;
	int pll_khz;

	always_comb begin
		rc_khz = rc_en_i ? 4000 * (int'(rc_freq_i) + 1) : 0;
		// a crystal that is off gives no clock even when chosen
		main_khz_o = on_xtal_i ? (xtal_en_i ? XTAL_KHZ : 0) : rc_khz;
		// divider first, then factor stored minus one
		pll_khz = (div_i == 8'h00) ? 0 : main_khz_o / int'(div_i) * (int'(factor_i) + 1);
		case (src_i)
			2'h1: mck_khz_o = main_khz_o;
			2'h2: mck_khz_o = pll_khz;
			default: mck_khz_o = 32;
		endcase
		mck_khz_o = mck_khz_o >> pres_i;
	end
endmodule

// [test/testbench.sv]
// self-checking bench for the main clock and pll sequencer
`timescale 1ns/1ps
module testbench;
	localparam int LIMIT = 30000;
	localparam int SD    = mcp_pkg::SLOW_DIV;
	localparam logic [31:0] MKEY = 32'(mcp_pkg::MOR_KEY) << mcp_pkg::MOR_KEY_LO;
	localparam logic [31:0] SKEY = 32'(mcp_pkg::SUP_KEY) << mcp_pkg::SUP_KEY_LO;
	logic        clk_i;
	logic        resetn_i;
	logic [7:0]  addr_i;
	logic [31:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [31:0] rdata_o;
	logic        rc_osc_enable_o;
	logic [1:0]  rc_freq_o;
	logic        xtal_osc_enable_o;
	logic        xtal_bypass_o;
	logic        main_on_xtal_o;
	logic [7:0]  pll_div_o;
	logic [10:0] pll_factor_up_o;
	logic [1:0]  mck_source_o;
	logic [2:0]  mck_prescale_o;
	logic        slow_on_xtal_o;
	logic        slow_clock_valid_o;
	int          main_khz;
	int          mck_khz;
	int          mismatches;
	int          n_tests;
	int          cyc;
	int          rel_cyc;
	int          n;
	logic [31:0] rd_val;

	mcp_main_clock_pll_sequencer u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.rc_osc_enable_o(rc_osc_enable_o), .rc_freq_o(rc_freq_o),
		.xtal_osc_enable_o(xtal_osc_enable_o), .xtal_bypass_o(xtal_bypass_o),
		.main_on_xtal_o(main_on_xtal_o), .pll_div_o(pll_div_o),
		.pll_factor_up_o(pll_factor_up_o), .mck_source_o(mck_source_o),
		.mck_prescale_o(mck_prescale_o), .slow_on_xtal_o(slow_on_xtal_o),
		.slow_clock_valid_o(slow_clock_valid_o));

	mcp_osc_model u_osc (.rc_en_i(rc_osc_enable_o), .rc_freq_i(rc_freq_o),
		.xtal_en_i(xtal_osc_enable_o), .on_xtal_i(main_on_xtal_o), .div_i(pll_div_o),
		.factor_i(pll_factor_up_o), .src_i(mck_source_o), .pres_i(mck_prescale_o),
		.main_khz_o(main_khz), .mck_khz_o(mck_khz));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// a hang ends in the same report
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [31:0] win(input int v, input int lo, input int hi);
		return {31'h0, (v >= lo && v <= hi)};
	endfunction

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	task automatic bus_rd(input logic [7:0] a);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		rd_val = rdata_o;
	endtask

	// cycles until a status bit rises; exceeds hi when it never does
	task automatic poll(input logic [7:0] a, input int b, input int hi, output int cnt);
		cnt = 0;
		do begin
			bus_rd(a);
			cnt += 2;
		end while (rd_val[b] !== 1'b1 && cnt <= hi);
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		check(32'({rc_osc_enable_o, rc_freq_o, xtal_osc_enable_o, main_on_xtal_o}), 32'h10);
		check(32'({mck_source_o, pll_div_o, pll_factor_up_o}), 32'h80000);
		check(32'(main_khz), 32'd4000);
		bus_rd(mcp_pkg::ADDR_STATUS);
		check(rd_val, 32'h8);
		while (cyc - rel_cyc < 3990) @(posedge clk_i);
		#1;
		check(32'({slow_clock_valid_o, slow_on_xtal_o}), 32'h0);
		while (cyc - rel_cyc < 4010) @(posedge clk_i);
		#1;
		check(32'({slow_clock_valid_o, slow_on_xtal_o}), 32'h2);
		bus_rd(8'h20);
		check(rd_val, 32'h0);
	endtask

	task automatic t_main_osc();
		bus_wr(mcp_pkg::ADDR_MAIN_OSC, MKEY | 32'h28);
		check(32'(rc_freq_o), 32'h2);
		check(32'(main_khz), 32'd12000);
		// a bypassed crystal needs no startup wait
		bus_wr(mcp_pkg::ADDR_MAIN_OSC, MKEY | 32'h2b);
		bus_rd(mcp_pkg::ADDR_STATUS);
		check(32'({xtal_bypass_o, rd_val[mcp_pkg::SR_XTAL_STABLE]}), 32'h3);
		bus_wr(mcp_pkg::ADDR_MAIN_OSC, MKEY | 32'h28);
		bus_rd(mcp_pkg::ADDR_STATUS);
		check(32'(rd_val[mcp_pkg::SR_XTAL_STABLE]), 32'h0);
		// missing key must leave the crystal off
		bus_wr(mcp_pkg::ADDR_MAIN_OSC, 32'h129);
		check(32'(xtal_osc_enable_o), 32'h0);
		bus_wr(mcp_pkg::ADDR_MAIN_OSC, MKEY | 32'h129);
		check(32'({xtal_osc_enable_o, xtal_bypass_o}), 32'h2);
		poll(mcp_pkg::ADDR_STATUS, mcp_pkg::SR_XTAL_STABLE, 9 * SD, n);
		check(win(n, (mcp_pkg::XTAL_UNIT - 1) * SD - 10, 9 * SD), 32'h1);
	endtask

	task automatic t_switch();
		bus_rd(mcp_pkg::ADDR_STATUS);
		check(32'(rd_val[mcp_pkg::SR_SRC_DONE]), 32'h0);
		bus_wr(mcp_pkg::ADDR_MAIN_OSC, MKEY | 32'h0100_0129);
		poll(mcp_pkg::ADDR_STATUS, mcp_pkg::SR_SRC_DONE, 12, n);
		check(win(n, 2, 12), 32'h1);
		check(32'(main_on_xtal_o), 32'h1);
	endtask

	task automatic t_pll();
		// 12 MHz in, divide by 1, factor 8: inside the limits
		bus_wr(mcp_pkg::ADDR_PLL_CONFIG, 32'h0007_0201);
		check(32'({pll_div_o, pll_factor_up_o}), 32'h807);
		bus_rd(mcp_pkg::ADDR_STATUS);
		check(32'(rd_val[mcp_pkg::SR_LOCK]), 32'h0);
		poll(mcp_pkg::ADDR_STATUS, mcp_pkg::SR_LOCK, 2 * SD + 20, n);
		check(win(n, SD - 10, 2 * SD + 20), 32'h1);
	endtask

	task automatic t_mck();
		// prescaler first on the main clock, then the pll
		bus_wr(mcp_pkg::ADDR_MASTER_CLK, 32'h11);
		bus_rd(mcp_pkg::ADDR_STATUS);
		check(32'(rd_val[mcp_pkg::SR_MCK_READY]), 32'h0);
		poll(mcp_pkg::ADDR_STATUS, mcp_pkg::SR_MCK_READY, 12, n);
		check(win(n, 0, 12), 32'h1);
		check(32'({mck_source_o, mck_prescale_o}), 32'h9);
		bus_wr(mcp_pkg::ADDR_MASTER_CLK, 32'h12);
		bus_rd(mcp_pkg::ADDR_STATUS);
		check(32'(rd_val[mcp_pkg::SR_MCK_READY]), 32'h0);
		poll(mcp_pkg::ADDR_STATUS, mcp_pkg::SR_MCK_READY, 12, n);
		check(win(n, 0, 12), 32'h1);
		check(32'(mck_khz), 32'd48000);
	endtask

	task automatic t_slow();
		bus_wr(mcp_pkg::ADDR_SUPPLY_CTL, 32'h8);
		repeat (8) @(posedge clk_i);
		bus_rd(mcp_pkg::ADDR_SUPPLY_ST);
		check(rd_val, 32'h0);
		bus_wr(mcp_pkg::ADDR_SUPPLY_CTL, SKEY | 32'h8);
		poll(mcp_pkg::ADDR_SUPPLY_ST, mcp_pkg::SUP_SRC_FLAG, 12, n);
		check(win(n, 2, 12), 32'h1);
		check(32'(slow_on_xtal_o), 32'h1);
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		addr_i = 8'h00;
		wdata_i = 32'h0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		resetn_i = 1'b0;
		mismatches = 0;
		n_tests = 0;
		cyc = 0;
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'b1;
		rel_cyc = cyc;
		repeat (4) @(posedge clk_i);
		t_reset();
		t_main_osc();
		t_switch();
		t_pll();
		t_mck();
		t_slow();
		wrap_up();
	end
endmodule
